// >>> rtl/ep_txn_handler.sv
// Endpoint transaction handler: OUT/IN/setup handling, X/Y buffers, replies.
// Assumes a packet engine that decodes tokens and serialises bytes, and APB.
//
// Contract
// - Good OUT packet: store, count, flip toggle, set hold, ACK, raise event.
// - OUT packet while hold bit is 1 gets NAK and is not stored.
// - Halt bit 1 answers STALL to OUT and IN tokens.
// - CRC or bit stuffing error on OUT data gets no handshake.
// - Endpoints 1 to 7 each way configurable for interrupt or bulk; the CFG_BULK bit is stored but changes nothing.
// - IN to ready endpoint sends buffer; host ACK flips toggle, sets hold, event.
// - IN token while hold bit is 1 gets NAK instead of data.
// - No host handshake after IN data: keep toggle and hold, resend later.
// - Double-buffered OUT writes buffer X on toggle 0, Y on toggle 1.
// - Double-buffered IN reads buffer X on toggle 0, Y on toggle 1.
// - Bulk endpoints work with single and double buffering.
// - Setup flag set forces NAK on endpoint 0 data and status stages.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ep_txn_defs.svh"

module ep_txn_handler (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 tok_valid,
    input  wire ep_txn_pkg::tok_e     tok_kind,
    input  wire logic [2:0]           tok_ep,
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 rx_end,
    input  wire logic                 rx_err,
    input  wire logic                 rx_data1,
    input  wire logic                 tx_ready,
    input  wire logic                 host_ack,
    input  wire logic                 host_timeout,
    output logic                      tx_valid,
    output logic      [7:0]           tx_byte,
    output logic                      tx_last,
    output logic                      tx_zlp,
    output logic                      tx_data1,
    output logic                      hs_valid,
    output ep_txn_pkg::hs_e           hs_code
);
    logic [7:0]          mem [`BUF_DEPTH];
    logic [31:0]         cfg_r [16];
    logic [31:0]         cfg_nxt [16];
    logic [15:0]         cnt_r [16];
    logic [15:0]         cnt_nxt [16];
    logic [15:0]         evt_r, evt_nxt;
    logic                setup_flag_r, setup_flag_nxt;
    ep_txn_pkg::st_e     st_r, st_nxt;
    ep_txn_pkg::hs_e     reply_r, reply_nxt;
    logic [3:0]          ep_r, ep_nxt;
    logic                setup_r, setup_nxt;
    logic                ysel_r, ysel_nxt;
    logic [7:0]          base_r, base_nxt;
    logic [7:0]          lim_r, lim_nxt;
    logic [7:0]          idx_r, idx_nxt;
    logic [31:0]         prdata_nxt;
    logic                pready_nxt, pslverr_nxt;
    logic                tx_valid_nxt, tx_last_nxt, tx_zlp_nxt, tx_data1_nxt;
    logic [7:0]          tx_byte_nxt;
    logic                hs_valid_nxt;
    ep_txn_pkg::hs_e     hs_code_nxt;
    logic                mem_we;
    logic [7:0]          mem_wa, mem_wd;
    logic [3:0]          tok_idx;
    logic [31:0]         tc;
    logic                tok_ysel, tok_hold;
    ep_txn_pkg::hs_e     tok_rep;
    logic                acc, is_cfg, is_stat, is_buf, link_free, commit;
    logic [3:0]          a_ep;
    logic [7:0]          a_mem;

    // Token decode and reply choice
    always_comb begin
        tok_idx  = {tok_kind == ep_txn_pkg::TK_IN, tok_ep};
        tc       = cfg_r[tok_idx];
        tok_ysel = tc[`CFG_DBUF] & tc[`CFG_TOG];
        tok_hold = tok_ysel ? tc[`CFG_HOLDY] : tc[`CFG_HOLDX];
        if (!tc[`CFG_EN]) begin
            tok_rep = ep_txn_pkg::HS_NONE;
        end else if (tok_ep == 3'h0 && setup_flag_r) begin
            tok_rep = ep_txn_pkg::HS_NAK;
        end else if (tc[`CFG_HALT]) begin
            tok_rep = ep_txn_pkg::HS_STALL;
        end else if (tok_hold) begin
            tok_rep = ep_txn_pkg::HS_NAK;
        end else begin
            tok_rep = ep_txn_pkg::HS_ACK;
        end
    end

    // APB decode; buffer access waits for an idle link to keep one memory writer
    always_comb begin
        acc       = psel & penable & ~pready;
        is_cfg    = paddr <= `OFF_EP_LAST;
        is_stat   = paddr == `OFF_STATUS;
        is_buf    = paddr[11:10] == `OFF_BUF_SEL;
        a_ep      = paddr[6:3];
        a_mem     = paddr[9:2];
        link_free = (st_r == ep_txn_pkg::ST_IDLE) & ~tok_valid;
        commit    = psel & penable & pready & pwrite & ~pslverr;
    end

    always_comb begin
        cfg_nxt        = cfg_r;
        cnt_nxt        = cnt_r;
        evt_nxt        = evt_r;
        setup_flag_nxt = setup_flag_r;
        st_nxt         = st_r;
        reply_nxt      = reply_r;
        ep_nxt         = ep_r;
        setup_nxt      = setup_r;
        ysel_nxt       = ysel_r;
        base_nxt       = base_r;
        lim_nxt        = lim_r;
        idx_nxt        = idx_r;
        tx_valid_nxt   = tx_valid;
        tx_byte_nxt    = tx_byte;
        tx_last_nxt    = tx_last;
        tx_zlp_nxt     = tx_zlp;
        tx_data1_nxt   = tx_data1;
        hs_valid_nxt   = 1'b0;
        hs_code_nxt    = hs_code;
        mem_we         = 1'b0;
        mem_wa         = a_mem;
        mem_wd         = pwdata[7:0];
        pready_nxt     = acc & (~is_buf | link_free);
        pslverr_nxt    = pready_nxt & ~(is_cfg | is_stat | is_buf);
        prdata_nxt     = 32'h0000_0000;
        if (pready_nxt) begin
            if (is_cfg) begin
                prdata_nxt = paddr[2] ? {16'h0000, cnt_r[a_ep]} : cfg_r[a_ep];
            end else if (is_stat) begin
                prdata_nxt = {15'h0000, setup_flag_r, evt_r};
            end else if (is_buf) begin
                prdata_nxt = {24'h00_0000, mem[a_mem]};
            end
        end
        // Firmware writes first so that hardware sets below win over clears
        if (commit) begin
            if (is_cfg && !paddr[2]) begin
                cfg_nxt[a_ep] = pwdata;
            end else if (is_cfg) begin
                cnt_nxt[a_ep] = pwdata[15:0];
            end else if (is_stat) begin
                evt_nxt        = evt_r & ~pwdata[15:0];
                setup_flag_nxt = setup_flag_r & ~pwdata[`STAT_SETUP];
            end else begin
                mem_we = 1'b1;
            end
        end
        unique case (st_r)
            ep_txn_pkg::ST_IDLE: begin
                if (tok_valid) begin
                    ep_nxt    = tok_idx;
                    ysel_nxt  = tok_ysel;
                    idx_nxt   = 8'h00;
                    setup_nxt = tok_kind == ep_txn_pkg::TK_SETUP;
                    base_nxt  = tok_ysel ? tc[`CFG_BASEY +: 8] : tc[`CFG_BASEX +: 8];
                    lim_nxt   = tc[`CFG_SIZE +: 8];
                    reply_nxt = tok_rep;
                    if (tok_kind == ep_txn_pkg::TK_SETUP) begin
                        base_nxt  = `SETUP_BASE;
                        lim_nxt   = `SETUP_LEN;
                        reply_nxt = ep_txn_pkg::HS_ACK;
                        st_nxt    = ep_txn_pkg::ST_RX;
                    end else if (tok_kind == ep_txn_pkg::TK_OUT) begin
                        st_nxt = ep_txn_pkg::ST_RX;
                    end else if (tok_rep == ep_txn_pkg::HS_ACK) begin
                        lim_nxt = tok_ysel ? cnt_r[tok_idx][15:8] : cnt_r[tok_idx][7:0];
                        st_nxt  = ep_txn_pkg::ST_TX;
                    end else if (tok_rep != ep_txn_pkg::HS_NONE) begin
                        hs_valid_nxt = 1'b1;
                        hs_code_nxt  = tok_rep;
                    end
                end
            end
            ep_txn_pkg::ST_RX: begin
                if (rx_valid && reply_r == ep_txn_pkg::HS_ACK && idx_r < lim_r) begin
                    mem_we  = 1'b1;
                    mem_wa  = base_r + idx_r;
                    mem_wd  = rx_byte;
                    idx_nxt = idx_r + 8'h01;
                end
                if (rx_end) begin
                    st_nxt = ep_txn_pkg::ST_IDLE;
                    // Corrupt packet: stay silent so the host retries
                    if (!rx_err && reply_r != ep_txn_pkg::HS_NONE) begin
                        hs_valid_nxt = 1'b1;
                        hs_code_nxt  = reply_r;
                    end
                    if (!rx_err && setup_r) begin
                        setup_flag_nxt = 1'b1;
                    end else if (!rx_err && reply_r == ep_txn_pkg::HS_ACK
                                 && rx_data1 == cfg_r[ep_r][`CFG_TOG]) begin
                        // Repeated packet with a stale PID is acked but dropped
                        // Flip on top of a same-cycle firmware write
                        cfg_nxt[ep_r][`CFG_TOG] = ~cfg_nxt[ep_r][`CFG_TOG];
                        if (ysel_r) begin
                            cnt_nxt[ep_r][15:8] = idx_nxt;
                            cfg_nxt[ep_r][`CFG_HOLDY] = 1'b1;
                        end else begin
                            cnt_nxt[ep_r][7:0] = idx_nxt;
                            cfg_nxt[ep_r][`CFG_HOLDX] = 1'b1;
                        end
                        evt_nxt[ep_r] = evt_nxt[ep_r] | cfg_r[ep_r][`CFG_IE];
                    end
                end
            end
            ep_txn_pkg::ST_TX: begin
                if (!tx_valid || tx_ready) begin
                    tx_valid_nxt = 1'b1;
                    tx_byte_nxt  = mem[base_r + idx_r];
                    tx_zlp_nxt   = lim_r == 8'h00;
                    tx_last_nxt  = (lim_r == 8'h00) || (idx_r == lim_r - 8'h01);
                    tx_data1_nxt = cfg_r[ep_r][`CFG_TOG];
                    idx_nxt      = idx_r + 8'h01;
                    if (tx_last_nxt) begin
                        st_nxt = ep_txn_pkg::ST_TXEND;
                    end
                end
            end
            ep_txn_pkg::ST_TXEND: begin
                if (tx_ready) begin
                    tx_valid_nxt = 1'b0;
                    tx_last_nxt  = 1'b0;
                    tx_zlp_nxt   = 1'b0;
                    st_nxt       = ep_txn_pkg::ST_WAIT;
                end
            end
            ep_txn_pkg::ST_WAIT: begin
                if (host_ack) begin
                    cfg_nxt[ep_r][`CFG_TOG] = ~cfg_nxt[ep_r][`CFG_TOG];
                    if (ysel_r) begin
                        cfg_nxt[ep_r][`CFG_HOLDY] = 1'b1;
                    end else begin
                        cfg_nxt[ep_r][`CFG_HOLDX] = 1'b1;
                    end
                    evt_nxt[ep_r] = evt_nxt[ep_r] | cfg_r[ep_r][`CFG_IE];
                    st_nxt = ep_txn_pkg::ST_IDLE;
                end else if (host_timeout) begin
                    st_nxt = ep_txn_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Buffer memory has no reset; contents are undefined until written
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                cfg_r[i] <= `CFG_RST;
                cnt_r[i] <= 16'h0000;
            end
            evt_r        <= 16'h0000;
            setup_flag_r <= 1'b0;
            st_r         <= ep_txn_pkg::ST_IDLE;
            reply_r      <= ep_txn_pkg::HS_NONE;
            ep_r         <= 4'h0;
            setup_r      <= 1'b0;
            ysel_r       <= 1'b0;
            base_r       <= 8'h00;
            lim_r        <= 8'h00;
            idx_r        <= 8'h00;
            prdata       <= 32'h0000_0000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            tx_valid     <= 1'b0;
            tx_byte      <= 8'h00;
            tx_last      <= 1'b0;
            tx_zlp       <= 1'b0;
            tx_data1     <= 1'b0;
            hs_valid     <= 1'b0;
            hs_code      <= ep_txn_pkg::HS_NONE;
        end else begin
            cfg_r        <= cfg_nxt;
            cnt_r        <= cnt_nxt;
            evt_r        <= evt_nxt;
            setup_flag_r <= setup_flag_nxt;
            st_r         <= st_nxt;
            reply_r      <= reply_nxt;
            ep_r         <= ep_nxt;
            setup_r      <= setup_nxt;
            ysel_r       <= ysel_nxt;
            base_r       <= base_nxt;
            lim_r        <= lim_nxt;
            idx_r        <= idx_nxt;
            prdata       <= prdata_nxt;
            pready       <= pready_nxt;
            pslverr      <= pslverr_nxt;
            tx_valid     <= tx_valid_nxt;
            tx_byte      <= tx_byte_nxt;
            tx_last      <= tx_last_nxt;
            tx_zlp       <= tx_zlp_nxt;
            tx_data1     <= tx_data1_nxt;
            hs_valid     <= hs_valid_nxt;
            hs_code      <= hs_code_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/ep_txn_defs.svh
// Offsets, field positions, reset values and sizes of the endpoint handler.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef EP_TXN_DEFS_SVH
`define EP_TXN_DEFS_SVH

// Endpoint n: config word at n*8, count word at n*8+4; OUT 0..7 then IN 0..7
`define OFF_EP_LAST   12'h07C
`define OFF_STATUS    12'h080
`define OFF_BUF_SEL   2'h1
`define CFG_EN        0
`define CFG_DBUF      1
`define CFG_HALT      2
`define CFG_TOG       3
`define CFG_HOLDX     4
`define CFG_HOLDY     5
`define CFG_IE        6
`define CFG_BULK      7
`define CFG_BASEX     8
`define CFG_BASEY     16
`define CFG_SIZE      24
`define CFG_RST       32'h0000_0030
`define STAT_SETUP    16
`define SETUP_BASE    8'hF8
`define SETUP_LEN     8'h08
`define BUF_DEPTH     256

`endif

// >>> rtl/ep_txn_pkg.sv
// Types shared by the endpoint transaction handler and its bench.
// Assumes nothing beyond the header of constants.
`default_nettype none
package ep_txn_pkg;
    typedef enum logic [1:0] {TK_OUT, TK_IN, TK_SETUP} tok_e;
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} hs_e;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_TX, ST_TXEND, ST_WAIT} st_e;
endpackage
`default_nettype wire

// >>> testbench/ep_txn_asserts.sv
// Assertions on the endpoint handler's APB and link ports.
// Bound onto every ep_txn_handler; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ep_txn_asserts (
    input wire logic             mclk,
    input wire logic             rst,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             tok_valid,
    input wire ep_txn_pkg::tok_e tok_kind,
    input wire logic             rx_end,
    input wire logic             rx_err,
    input wire logic             tx_valid,
    input wire logic             tx_ready,
    input wire logic [7:0]       tx_byte,
    input wire logic             tx_last,
    input wire logic             hs_valid,
    input wire ep_txn_pkg::hs_e  hs_code
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire in_tok = tok_valid && tok_kind == ep_txn_pkg::TK_IN;
    chk_err_silent: assert property (rx_end && rx_err |=> !hs_valid)
        else $error("handshake after damaged packet");
    chk_hs_cause: assert property (hs_valid |-> $past(rx_end) || $past(in_tok))
        else $error("handshake without cause");
    chk_hs_single: assert property (hs_valid |=> !hs_valid)
        else $error("handshake longer than one cycle");
    chk_in_answer: assert property (in_tok |-> (##1 hs_valid) or (##2 tx_valid))
        else $error("no reply to in token");
    chk_refuse_quiet: assert property (in_tok ##1 hs_valid |=> (!tx_valid) [*3])
        else $error("data after refusal");
    chk_beat_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
        else $error("beat changed before accepted");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    cover property (hs_valid && hs_code == ep_txn_pkg::HS_ACK);
    cover property (hs_valid && hs_code == ep_txn_pkg::HS_NAK);
    cover property (hs_valid && hs_code == ep_txn_pkg::HS_STALL);
    cover property (tx_valid && tx_ready && tx_last);
endmodule
bind ep_txn_handler ep_txn_asserts i_chk (.*);
`default_nettype wire

// >>> testbench/host_model.sv
// Host side of the link: tokens, OUT data, IN reception and handshakes.
// Driven by tasks of the bench; changes signals just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic             mclk,
    output logic                  tok_valid,
    output ep_txn_pkg::tok_e      tok_kind,
    output logic [2:0]            tok_ep,
    output logic                  rx_valid,
    output logic [7:0]            rx_byte,
    output logic                  rx_end,
    output logic                  rx_err,
    output logic                  rx_data1,
    output logic                  tx_ready,
    output logic                  host_ack,
    output logic                  host_timeout,
    input  wire logic             tx_valid,
    input  wire logic [7:0]       tx_byte,
    input  wire logic             tx_last,
    input  wire logic             tx_zlp,
    input  wire logic             tx_data1,
    input  wire logic             hs_valid,
    input  wire ep_txn_pkg::hs_e  hs_code
);
    logic slow;
    logic hang;
    initial begin
        {tok_valid, rx_valid, rx_end, rx_err, rx_data1, host_ack, host_timeout, slow, hang} = '0;
        tok_kind = ep_txn_pkg::TK_OUT;
        tok_ep = 3'h0;
        rx_byte = 8'h5A;
        tx_ready = 1'h1;
    end
    task automatic send_tok(input ep_txn_pkg::tok_e k, input logic [2:0] ep);
        @(posedge mclk);
        tok_valid <= 1'h1;
        tok_kind <= k;
        tok_ep <= ep;
    endtask
    task automatic out_pkt(input ep_txn_pkg::tok_e k, input logic [2:0] ep, input int n, input logic [7:0] b,
                           input logic d1, input logic er, output ep_txn_pkg::hs_e hs);
        send_tok(k, ep);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            tok_valid <= 1'h0;
            rx_valid <= 1'h1;
            rx_byte <= b + 8'(i);
        end
        @(posedge mclk);
        {tok_valid, rx_valid} <= 2'h0;
        rx_byte <= ~rx_byte;
        {rx_end, rx_err, rx_data1} <= {1'h1, er, d1};
        @(posedge mclk);
        {rx_end, rx_err, rx_data1} <= 3'h0;
        hs = ep_txn_pkg::HS_NONE;
        repeat (3) begin
            @(posedge mclk);
            if (hs_valid === 1'h1) hs = hs_code;
        end
    endtask
    // Slow mode drops tx_ready every other cycle to exercise the hold of tx data
    task automatic in_pkt(input logic [2:0] ep, input logic ack, output ep_txn_pkg::hs_e hs,
                          output logic [7:0] q[$], output logic d1);
        logic done;
        send_tok(ep_txn_pkg::TK_IN, ep);
        @(posedge mclk);
        tok_valid <= 1'h0;
        hs = ep_txn_pkg::HS_NONE;
        q = {};
        d1 = 1'h0;
        done = 1'h0;
        for (int j = 0; j < 40 && !done; j++) begin
            @(posedge mclk);
            if (hs_valid === 1'h1) begin
                hs = hs_code;
                done = 1'h1;
            end else if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
                if (tx_zlp !== 1'h1) q.push_back(tx_byte);
                d1 = tx_data1;
                done = tx_last === 1'h1;
            end
            tx_ready <= slow ? ~tx_ready : 1'h1;
        end
        hang = !done;
        if (done && hs == ep_txn_pkg::HS_NONE) begin
            @(posedge mclk);
            {host_ack, host_timeout} <= {ack, !ack};
            @(posedge mclk);
            {host_ack, host_timeout} <= 2'h0;
            repeat (2) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_usb_endpoint_transaction_handler.sv
// Self-checking bench: firmware over APB, host through host_model.
// Assumes the handler's register map and field positions.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_usb_endpoint_transaction_handler;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, tok_valid, rx_valid, rx_end, rx_err;
    logic rx_data1, tx_ready, host_ack, host_timeout, tx_valid, tx_last, tx_zlp, tx_data1, hs_valid, d1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rx_byte, tx_byte;
    logic [7:0] q[$];
    logic [2:0] tok_ep;
    ep_txn_pkg::tok_e tok_kind;
    ep_txn_pkg::hs_e hs_code, hs;
    int errors, check_count;
    ep_txn_handler i_dut (.*);
    host_model i_host (.*);
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    task automatic test_done();
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge mclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        if (pready !== 1'h1) begin
            errors++;
            test_done();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        `CHK(r, x)
    endtask
    task automatic out(input ep_txn_pkg::tok_e k, input logic [2:0] ep, input int n, input logic [7:0] b,
                       input logic p1, input logic er, input ep_txn_pkg::hs_e x);
        i_host.out_pkt(k, ep, n, b, p1, er, hs);
        `CHK(hs, x)
    endtask
    task automatic inp(input logic ack, input ep_txn_pkg::hs_e x, input int n, input logic [7:0] b, input logic x1);
        i_host.in_pkt(3'h1, ack, hs, q, d1);
        if (i_host.hang) begin
            errors++;
            test_done();
        end
        `CHK(hs, x)
        `CHK(q.size(), n)
        foreach (q[i]) `CHK(q[i], b + 8'(i))
        `CHK(d1, x1)
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(12'h018, 32'h0000_0030);
        apb(1'h0, 12'h084, 32'h0, r, e);
        `CHK({e, r}, 33'h1_0000_0000)
        out(ep_txn_pkg::TK_OUT, 3'h2, 1, 8'h33, 1'h0, 1'h0, ep_txn_pkg::HS_NONE);
    endtask
    task automatic t_out_single();
        wr(12'h008, 32'h1000_2041);
        out(ep_txn_pkg::TK_OUT, 3'h1, 3, 8'h11, 1'h0, 1'h0, ep_txn_pkg::HS_ACK);
        rd(12'h00C, 32'h3);
        rd(12'h488, 32'h13);
        rd(12'h008, 32'h1000_2059);
        rd(12'h080, 32'h2);
        out(ep_txn_pkg::TK_OUT, 3'h1, 2, 8'h77, 1'h1, 1'h0, ep_txn_pkg::HS_NAK);
        rd(12'h480, 32'h11);
        wr(12'h080, 32'h2);
        wr(12'h008, 32'h1000_2049);
        out(ep_txn_pkg::TK_OUT, 3'h1, 2, 8'h77, 1'h1, 1'h1, ep_txn_pkg::HS_NONE);
        rd(12'h008, 32'h1000_2049);
        out(ep_txn_pkg::TK_OUT, 3'h1, 1, 8'h77, 1'h0, 1'h0, ep_txn_pkg::HS_ACK);
        rd(12'h008, 32'h1000_2049);
        rd(12'h00C, 32'h3);
        wr(12'h008, 32'h1000_205D);
        out(ep_txn_pkg::TK_OUT, 3'h1, 1, 8'h77, 1'h1, 1'h0, ep_txn_pkg::HS_STALL);
    endtask
    task automatic t_dbuf_bulk();
        wr(12'h038, 32'h1040_30C3);
        out(ep_txn_pkg::TK_OUT, 3'h7, 2, 8'h51, 1'h0, 1'h0, ep_txn_pkg::HS_ACK);
        out(ep_txn_pkg::TK_OUT, 3'h7, 2, 8'h61, 1'h1, 1'h0, ep_txn_pkg::HS_ACK);
        out(ep_txn_pkg::TK_OUT, 3'h7, 1, 8'h71, 1'h0, 1'h0, ep_txn_pkg::HS_NAK);
        rd(12'h038, 32'h1040_30F3);
        rd(12'h03C, 32'h0202);
        rd(12'h4C4, 32'h52);
        rd(12'h504, 32'h62);
        rd(12'h080, 32'h80);
    endtask
    task automatic t_ep0_status();
        wr(12'h000, 32'h0800_0049);
        out(ep_txn_pkg::TK_SETUP, 3'h0, 8, 8'h80, 1'h0, 1'h0, ep_txn_pkg::HS_ACK);
        out(ep_txn_pkg::TK_OUT, 3'h0, 0, 8'h0, 1'h1, 1'h0, ep_txn_pkg::HS_NAK);
        wr(12'h080, 32'h0001_FFFF);
        out(ep_txn_pkg::TK_OUT, 3'h0, 0, 8'h0, 1'h1, 1'h0, ep_txn_pkg::HS_ACK);
        rd(12'h000, 32'h0800_0051);
        rd(12'h004, 32'h0);
        rd(12'h080, 32'h1);
    endtask
    task automatic t_in_retry();
        wr(12'h080, 32'h0001_FFFF);
        for (int i = 0; i < 3; i++) wr(12'h580 + 12'(4 * i), 32'hA1 + 32'(i));
        wr(12'h04C, 32'h0103);
        wr(12'h048, 32'h1000_6051);
        inp(1'h1, ep_txn_pkg::HS_NAK, 0, 8'h0, 1'h0);
        wr(12'h048, 32'h1000_6041);
        i_host.slow = 1'h1;
        inp(1'h0, ep_txn_pkg::HS_NONE, 3, 8'hA1, 1'h0);
        rd(12'h048, 32'h1000_6041);
        inp(1'h1, ep_txn_pkg::HS_NONE, 3, 8'hA1, 1'h0);
        rd(12'h048, 32'h1000_6059);
        rd(12'h080, 32'h200);
        wr(12'h5C0, 32'hB7);
        wr(12'h048, 32'h1070_605B);
        inp(1'h1, ep_txn_pkg::HS_NONE, 1, 8'hB7, 1'h1);
        wr(12'h04C, 32'h0);
        wr(12'h048, 32'h1000_6049);
        inp(1'h1, ep_txn_pkg::HS_NONE, 0, 8'h0, 1'h1);
        wr(12'h048, 32'h1000_605D);
        inp(1'h1, ep_txn_pkg::HS_STALL, 0, 8'h0, 1'h0);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        errors = 0;
        check_count = 0;
        rst = 1'h1;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        t_reset();
        t_out_single();
        t_dbuf_bulk();
        t_ep0_status();
        t_in_retry();
        test_done();
    end
endmodule
`default_nettype wire
